// ---- pkg/link_cfg.svh ----
// constants for the serial packet link: characters, symbol codes, crc, fields
`ifndef LINK_CFG_SVH
`define LINK_CFG_SVH
`define PKT_DELIM_CHAR 8'h7c
`define PLAIN_SYM_CHAR 8'h1c
`define ST0_ACC     3'h0
`define ST0_RETRY   3'h1
`define ST0_NACC    3'h2
`define ST0_STATUS  3'h4
`define ST1_SOP     3'h0
`define ST1_EOP     3'h2
`define ST1_NOP     3'h7
`define CMD_NONE    3'h0
`define CAUSE_NONE  5'h00
`define CAUSE_FULL  5'h01
`define CAUSE_CHAR  5'h02
`define CAUSE_CRC   5'h04
`define CRC16_INIT  16'hffff
`define CRC16_POLY  16'h1021
`define CRC5_INIT   5'h1f
`define CRC5_POLY   5'h15
`define CRC_MASK    32'h03ff_ffff
`define PAD16       16'h0000
`define MIN_WORDS   4'h3
`define FT_RESP     4'hd
`define TT_RESP     4'h0
`define RESP_ERROR  4'h7
`endif

// ---- pkg/link_pkg.sv ----
// types and crc helpers shared by both link ends
`include "link_cfg.svh"
package link_pkg;

   typedef enum logic [4:0] {
      CL_DISCARD   = 5'h00,
      CL_UNSUP     = 5'h01,
      CL_NREAD     = 5'h02,
      CL_ATOM_INC  = 5'h03,
      CL_ATOM_DEC  = 5'h04,
      CL_ATOM_SET  = 5'h05,
      CL_ATOM_CLR  = 5'h06,
      CL_NWRITE    = 5'h07,
      CL_NWRITE_R  = 5'h08,
      CL_ATOM_TS   = 5'h09,
      CL_SWRITE    = 5'h0a,
      CL_CONGEST   = 5'h0b,
      CL_MT_RD     = 5'h0c,
      CL_MT_WR     = 5'h0d,
      CL_MT_RD_RSP = 5'h0e,
      CL_MT_WR_RSP = 5'h0f,
      CL_MT_PW     = 5'h10,
      CL_DOORBELL  = 5'h11,
      CL_MESSAGE   = 5'h12,
      CL_RESP      = 5'h13,
      CL_MSG_RESP  = 5'h14,
      CL_RESP_DATA = 5'h15
   } pkt_class_type;

   typedef struct packed {
      pkt_class_type cls;
      logic [3:0]    ftype;
      logic [3:0]    ttype;
      logic [7:0]    dest;
      logic [7:0]    src;
   } pkt_desc_type;

   // msb first over one word
   function automatic logic [15:0] crc16_word(input logic [15:0] c,
                                              input logic [31:0] w);
      logic [15:0] r;
      r = c;
      for (int i = 31; i >= 0; i--) begin
         r = {r[14:0], 1'b0} ^ ((r[15] ^ w[i]) ? `CRC16_POLY : 16'h0000);
      end
      return r;
   endfunction : crc16_word

   function automatic logic [4:0] crc5_sym(input logic [18:0] f);
      logic [4:0] r;
      r = `CRC5_INIT;
      for (int i = 18; i >= 0; i--) begin
         r = {r[3:0], 1'b0} ^ ((r[4] ^ f[i]) ? `CRC5_POLY : 5'h00);
      end
      return r;
   endfunction : crc5_sym

   // delimiting symbols get the packet char, all others the plain char
   function automatic logic [31:0] make_sym(input logic [2:0] st0,
                                            input logic [4:0] p0,
                                            input logic [4:0] p1,
                                            input logic [2:0] st1,
                                            input logic [2:0] cmd);
      logic [18:0] f;
      logic [7:0]  d;
      f = {st0, p0, p1, st1, cmd};
      d = (st1 == `ST1_SOP || st1 == `ST1_EOP) ? `PKT_DELIM_CHAR
                                               : `PLAIN_SYM_CHAR;
      return {d, f, crc5_sym(f)};
   endfunction : make_sym

   function automatic logic sym_good(input logic [31:0] s);
      logic [7:0] d;
      d = (s[10:8] == `ST1_SOP || s[10:8] == `ST1_EOP) ? `PKT_DELIM_CHAR
                                                       : `PLAIN_SYM_CHAR;
      return (s[31:24] == d) && (crc5_sym(s[23:5]) == s[4:0]);
   endfunction : sym_good

endpackage : link_pkg

// ---- pkg/link_if.sv ----
// word link between initiator end and target end
interface link_if;
   logic        fwd_valid;
   logic        fwd_k;
   logic [31:0] fwd_data;
   logic        bwd_valid;
   logic        bwd_k;
   logic [31:0] bwd_data;

   modport target (input  fwd_valid, fwd_k, fwd_data,
                   output bwd_valid, bwd_k, bwd_data);
   modport initiator (output fwd_valid, fwd_k, fwd_data,
                      input  bwd_valid, bwd_k, bwd_data);
endinterface : link_if

// ---- rtl/initiator_end.sv ----
// initiator end: frames requests, retries on not-accepted, sees error replies
`include "link_cfg.svh"
module initiator_end
   import link_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   link_if.initiator        lk,
   input  wire logic        i_req_valid,
   input  wire logic [3:0]  i_req_ftype,
   input  wire logic [3:0]  i_req_ttype,
   input  wire logic [7:0]  i_req_dest,
   input  wire logic [7:0]  i_req_src,
   input  wire logic [31:0] i_req_data,
   output logic             o_req_ready,
   output logic             o_done,
   output logic             o_retry,
   output logic             o_err_resp
);

   typedef enum logic [7:0] {
      IN_IDLE = 8'h01, IN_SOP = 8'h02, IN_W0  = 8'h04, IN_W1 = 8'h08,
      IN_W2   = 8'h10, IN_CRC = 8'h20, IN_EOP = 8'h40, IN_WAIT = 8'h80
   } init_state_type;

   init_state_type state_reg, state_next;
   logic [4:0]  seq_id_reg, seq_id_next;
   logic [15:0] crc_reg, crc_next;
   logic [31:0] w0_reg, w0_next, w1_reg, w1_next, w2_reg, w2_next;
   logic        ready_reg, ready_next, done_reg, done_next;
   logic        retry_reg, retry_next;
   logic        fv_reg, fv_next, fk_reg, fk_next;
   logic [31:0] fd_reg, fd_next;
   logic [1:0]  ridx_reg, ridx_next;
   logic        rerr_reg, rerr_next, eresp_reg, eresp_next;
   logic        bsym;

   assign bsym = lk.bwd_valid && lk.bwd_k && sym_good(lk.bwd_data);

   always_comb begin
      state_next = state_reg;
      seq_id_next = seq_id_reg;
      crc_next   = crc_reg;
      w0_next    = w0_reg;
      w1_next    = w1_reg;
      w2_next    = w2_reg;
      done_next  = 1'b0;
      retry_next = 1'b0;
      fv_next    = 1'b0;
      fk_next    = 1'b0;
      fd_next    = 32'h0000_0000;
      unique case (state_reg)
         IN_IDLE: begin
            if (i_req_valid && ready_reg) begin
               // reserved header bits are sent as zero
               w0_next = {seq_id_reg, 3'h0, 4'h0, i_req_ftype,
                          i_req_dest, i_req_src};
               w1_next = {i_req_ttype, 28'h000_0000};
               w2_next = i_req_data;
               state_next = IN_SOP;
            end
         end
         IN_SOP: begin
            fv_next = 1'b1;
            fk_next = 1'b1;
            fd_next = make_sym(`ST0_STATUS, seq_id_reg, `CAUSE_NONE,
                               `ST1_SOP, `CMD_NONE);
            crc_next = `CRC16_INIT;
            w0_next = {seq_id_reg, w0_reg[26:0]};
            state_next = IN_W0;
         end
         IN_W0: begin
            fv_next = 1'b1;
            fd_next = w0_reg;
            crc_next = crc16_word(crc_reg, w0_reg & `CRC_MASK);
            state_next = IN_W1;
         end
         IN_W1: begin
            fv_next = 1'b1;
            fd_next = w1_reg;
            crc_next = crc16_word(crc_reg, w1_reg);
            state_next = IN_W2;
         end
         IN_W2: begin
            fv_next = 1'b1;
            fd_next = w2_reg;
            crc_next = crc16_word(crc_reg, w2_reg);
            state_next = IN_CRC;
         end
         IN_CRC: begin
            // crc ends on a half word, so a zero pad fills the word
            fv_next = 1'b1;
            fd_next = {crc_reg, `PAD16};
            state_next = IN_EOP;
         end
         IN_EOP: begin
            fv_next = 1'b1;
            fk_next = 1'b1;
            fd_next = make_sym(`ST0_STATUS, seq_id_reg, `CAUSE_NONE,
                               `ST1_EOP, `CMD_NONE);
            state_next = IN_WAIT;
         end
         IN_WAIT: begin
            if (bsym && lk.bwd_data[10:8] == `ST1_NOP) begin
               if (lk.bwd_data[23:21] == `ST0_ACC) begin
                  done_next  = 1'b1;
                  seq_id_next = seq_id_reg + 5'h01;
                  state_next = IN_IDLE;
               end else if (lk.bwd_data[23:21] == `ST0_NACC) begin
                  retry_next = 1'b1;
                  state_next = IN_SOP;
               end
            end
         end
      endcase
      ready_next = (state_next == IN_IDLE);
   end

   // error reply watcher; a reply is only header plus crc here
   always_comb begin
      ridx_next  = ridx_reg;
      rerr_next  = rerr_reg;
      eresp_next = 1'b0;
      if (bsym && lk.bwd_data[10:8] == `ST1_SOP) begin
         ridx_next = 2'h1;
         rerr_next = 1'b0;
      end else if (bsym && lk.bwd_data[10:8] == `ST1_EOP) begin
         eresp_next = rerr_reg && (ridx_reg == 2'h3);
         ridx_next  = 2'h0;
      end else if (lk.bwd_valid && !lk.bwd_k && ridx_reg != 2'h0) begin
         if (ridx_reg == 2'h1) begin
            rerr_next = (lk.bwd_data[19:16] == `FT_RESP);
         end else if (ridx_reg == 2'h2) begin
            rerr_next = rerr_reg && (lk.bwd_data[27:24] == `RESP_ERROR);
         end
         if (ridx_reg != 2'h3) begin
            ridx_next = ridx_reg + 2'h1;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         state_reg <= IN_IDLE;
         seq_id_reg <= 5'h00;
         crc_reg   <= `CRC16_INIT;
         w0_reg    <= 32'h0000_0000;
         w1_reg    <= 32'h0000_0000;
         w2_reg    <= 32'h0000_0000;
         ready_reg <= 1'b0;
         done_reg  <= 1'b0;
         retry_reg <= 1'b0;
         fv_reg    <= 1'b0;
         fk_reg    <= 1'b0;
         fd_reg    <= 32'h0000_0000;
         ridx_reg  <= 2'h0;
         rerr_reg  <= 1'b0;
         eresp_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         seq_id_reg <= seq_id_next;
         crc_reg   <= crc_next;
         w0_reg    <= w0_next;
         w1_reg    <= w1_next;
         w2_reg    <= w2_next;
         ready_reg <= ready_next;
         done_reg  <= done_next;
         retry_reg <= retry_next;
         fv_reg    <= fv_next;
         fk_reg    <= fk_next;
         fd_reg    <= fd_next;
         ridx_reg  <= ridx_next;
         rerr_reg  <= rerr_next;
         eresp_reg <= eresp_next;
      end
   end

   assign lk.fwd_valid = fv_reg;
   assign lk.fwd_k     = fk_reg;
   assign lk.fwd_data  = fd_reg;
   assign o_req_ready  = ready_reg;
   assign o_done       = done_reg;
   assign o_retry      = retry_reg;
   assign o_err_resp   = eresp_reg;

endmodule : initiator_end

// ---- rtl/target_end.sv ----
// target end: checks frames, answers with symbols, decodes packet types
// Summary of operation
// - request gets a response to complete transaction; here only unsupported types get one (error), others end at the accepted symbol
// - packets are whole 32-bit words long
// - half-word ending gets zero pad after crc
// - reserved bits sent zero, ignored on receive
// - device id field is eight bits
// - crc skips sequence id and one bit
// - good crc answered with accepted symbol; while the buffer is full it gets not-accepted instead
// - bad crc answered not-accepted; sender retries
// - packets framed by start and end symbols
// - symbols are 24 bits with own crc
// - delimiter then fields 3,5,5,3,3,5 bits
// - first type reports status, second requests
// - delimiting symbols use the packet char
// - other symbols use the plain char
// - bad delimiter char answered as not-accepted
// - no end delimiter after a symbol
// - undefined format types dropped before logical units
// - unsupported types get an error response
// - format 2: read and atomics decode
// - formats 5, 6, 7 decode
// - format 8 maintenance decode
// - formats 10, 11, 13 decode
// - accept primary id, or secondary in multicast
`include "link_cfg.svh"
module target_end
   import link_pkg::*;
(
   input  wire logic         i_clk,
   input  wire logic         i_rst_n,
   link_if.target            lk,
   input  wire logic [7:0]   i_primary_id,
   input  wire logic [7:0]   i_secondary_id,
   input  wire logic         i_multicast_en,
   input  wire logic         i_pkt_ready,
   output logic              o_pkt_valid,
   output pkt_desc_type      o_pkt,
   output logic              o_discard,
   output logic              o_nack
);

   typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_BODY = 2'b10} rx_state_type;

   typedef enum logic [5:0] {
      RP_IDLE = 6'h01, RP_SOP = 6'h02, RP_HDR0 = 6'h04,
      RP_HDR1 = 6'h08, RP_CRC = 6'h10, RP_EOP  = 6'h20
   } reply_state_type;

   function automatic pkt_class_type classify(input logic [3:0] ft,
                                              input logic [3:0] tt);
      pkt_class_type c;
      c = CL_UNSUP;
      unique case (ft)
         4'h2: begin
            unique case (tt)
               4'h4:    c = CL_NREAD;
               4'hc:    c = CL_ATOM_INC;
               4'hd:    c = CL_ATOM_DEC;
               4'he:    c = CL_ATOM_SET;
               4'hf:    c = CL_ATOM_CLR;
               default: c = CL_UNSUP;
            endcase
         end
         4'h5: begin
            unique case (tt)
               4'h4:    c = CL_NWRITE;
               4'h5:    c = CL_NWRITE_R;
               4'he:    c = CL_ATOM_TS;
               default: c = CL_UNSUP;
            endcase
         end
         4'h6: c = CL_SWRITE;
         4'h7: c = CL_CONGEST;
         4'h8: begin
            unique case (tt)
               4'h0:    c = CL_MT_RD;
               4'h1:    c = CL_MT_WR;
               4'h2:    c = CL_MT_RD_RSP;
               4'h3:    c = CL_MT_WR_RSP;
               4'h4:    c = CL_MT_PW;
               default: c = CL_UNSUP;
            endcase
         end
         4'ha: c = CL_DOORBELL;
         4'hb: c = CL_MESSAGE;
         4'hd: begin
            unique case (tt)
               4'h0:    c = CL_RESP;
               4'h1:    c = CL_MSG_RESP;
               4'h8:    c = CL_RESP_DATA;
               default: c = CL_UNSUP;
            endcase
         end
         // format 0 counts as defined but unsupported
         4'h0: c = CL_UNSUP;
         default: c = CL_DISCARD; // 1,3,4,9,12,14,15
      endcase
      return c;
   endfunction : classify

   rx_state_type    state_reg, state_next;
   reply_state_type rp_reg, rp_next;
   logic [3:0]   cnt_reg, cnt_next;
   logic [15:0]  crc_reg, crc_next;
   logic [31:0]  last_reg, last_next, hdr0_reg, hdr0_next;
   logic [31:0]  hdr1_reg, hdr1_next;
   logic [7:0]   rdest_reg, rdest_next;
   logic         bv_reg, bv_next, bk_reg, bk_next;
   logic [31:0]  bd_reg, bd_next;
   logic         disc_reg, disc_next, nack_reg, nack_next;
   logic         v0_reg, v0_next, v1_reg, v1_next;
   pkt_desc_type d0_reg, d0_next, d1_reg, d1_next;

   logic          is_sym, is_word, sym_ok, bad_sym, eop, frame_ok;
   logic          id_hit, accept, reject, push, want_resp, discard;
   logic [2:0]    st1;
   logic [4:0]    cause;
   logic [31:0]   rh0, rh1;
   pkt_class_type cls;
   pkt_desc_type  nd;

   // field split symbol crc and char checked together
   assign st1     = lk.fwd_data[10:8];
   assign is_sym  = lk.fwd_valid && lk.fwd_k;
   assign is_word = lk.fwd_valid && !lk.fwd_k;
   assign sym_ok  = sym_good(lk.fwd_data);
   assign bad_sym = is_sym && !sym_ok;
   assign eop     = is_sym && sym_ok && st1 == `ST1_EOP &&
                    state_reg == RX_BODY;
   // word framing makes length whole words; last word is crc plus pad
   assign frame_ok = cnt_reg >= `MIN_WORDS &&
                     last_reg[31:16] == crc_reg &&
                     last_reg[15:0] == `PAD16;
   // header bits outside the named fields are never looked at
   assign cls = classify(hdr0_reg[19:16], hdr1_reg[31:28]);
   assign id_hit = hdr0_reg[15:8] == i_primary_id ||
                   (i_multicast_en &&
                    hdr0_reg[15:8] == i_secondary_id);
   // a full buffer refuses the frame so the sender's retry keeps it
   assign accept    = eop && frame_ok && !v1_reg;
   assign reject    = bad_sym || (eop && !accept);
   assign push      = accept && id_hit &&
                      cls != CL_DISCARD && cls != CL_UNSUP;
   assign want_resp = accept && id_hit && cls == CL_UNSUP;
   assign discard   = accept && (!id_hit || cls == CL_DISCARD);
   assign cause = bad_sym ? `CAUSE_CHAR : (v1_reg && frame_ok) ?
                  `CAUSE_FULL : `CAUSE_CRC;
   assign nd = '{cls: cls, ftype: hdr0_reg[19:16],
                 ttype: hdr1_reg[31:28], dest: hdr0_reg[15:8],
                 src: hdr0_reg[7:0]};
   // error reply header; reserved bits zero
   assign rh0 = {5'h00, 3'h0, 4'h0, `FT_RESP, rdest_reg, i_primary_id};
   assign rh1 = {`TT_RESP, `RESP_ERROR, 24'h00_0000};

   // receive framing and running crc
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      crc_next   = crc_reg;
      last_next  = last_reg;
      hdr0_next  = hdr0_reg;
      hdr1_next  = hdr1_reg;
      if (is_sym && sym_ok && st1 == `ST1_SOP) begin
         state_next = RX_BODY;
         cnt_next   = 4'h0;
         crc_next   = `CRC16_INIT;
      end else if (eop || bad_sym) begin
         state_next = RX_IDLE;
      end else if (is_word && state_reg == RX_BODY) begin
         // crc trails one word so the crc word itself is left out
         if (cnt_reg == 4'h1) begin
            crc_next = crc16_word(crc_reg, last_reg & `CRC_MASK);
         end else if (cnt_reg != 4'h0) begin
            crc_next = crc16_word(crc_reg, last_reg);
         end
         last_next = lk.fwd_data;
         if (cnt_reg == 4'h0) begin
            hdr0_next = lk.fwd_data;
         end
         if (cnt_reg == 4'h1) begin
            hdr1_next = lk.fwd_data;
         end
         if (cnt_reg != 4'hf) begin
            cnt_next = cnt_reg + 4'h1;
         end
      end
   end

   // reply stream: ack symbol, then optional error response packet.
   // events during a reply are lost; the sender holds one packet open.
   always_comb begin
      rp_next    = rp_reg;
      rdest_next = rdest_reg;
      bv_next    = 1'b0;
      bk_next    = 1'b0;
      bd_next    = 32'h0000_0000;
      disc_next  = discard;
      nack_next  = reject;
      unique case (rp_reg)
         RP_IDLE: begin
            if (accept || reject) begin
               bv_next = 1'b1;
               bk_next = 1'b1;
               bd_next = make_sym(accept ? `ST0_ACC : `ST0_NACC,
                                  hdr0_reg[31:27],
                                  accept ? `CAUSE_NONE : cause,
                                  `ST1_NOP, `CMD_NONE);
               rdest_next = hdr0_reg[7:0];
               rp_next = want_resp ? RP_SOP : RP_IDLE;
            end
         end
         RP_SOP: begin
            bv_next = 1'b1;
            bk_next = 1'b1;
            bd_next = make_sym(`ST0_STATUS, `CAUSE_NONE, `CAUSE_NONE,
                               `ST1_SOP, `CMD_NONE);
            rp_next = RP_HDR0;
         end
         RP_HDR0: begin
            bv_next = 1'b1;
            bd_next = rh0;
            rp_next = RP_HDR1;
         end
         RP_HDR1: begin
            bv_next = 1'b1;
            bd_next = rh1;
            rp_next = RP_CRC;
         end
         RP_CRC: begin
            bv_next = 1'b1;
            bd_next = {crc16_word(crc16_word(`CRC16_INIT,
                                             rh0 & `CRC_MASK), rh1),
                       `PAD16};
            rp_next = RP_EOP;
         end
         RP_EOP: begin
            bv_next = 1'b1;
            bk_next = 1'b1;
            bd_next = make_sym(`ST0_STATUS, `CAUSE_NONE, `CAUSE_NONE,
                               `ST1_EOP, `CMD_NONE);
            rp_next = RP_IDLE;
         end
      endcase
   end

   // two-entry descriptor buffer toward the logical units
   always_comb begin
      v0_next = v0_reg;
      v1_next = v1_reg;
      d0_next = d0_reg;
      d1_next = d1_reg;
      if (v0_reg && i_pkt_ready) begin
         v0_next = v1_reg;
         d0_next = d1_reg;
         v1_next = 1'b0;
      end
      if (push) begin
         if (!v0_next) begin
            v0_next = 1'b1;
            d0_next = nd;
         end else begin
            v1_next = 1'b1;
            d1_next = nd;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         state_reg <= RX_IDLE;
         cnt_reg   <= 4'h0;
         crc_reg   <= `CRC16_INIT;
         last_reg  <= 32'h0000_0000;
         hdr0_reg  <= 32'h0000_0000;
         hdr1_reg  <= 32'h0000_0000;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         crc_reg   <= crc_next;
         last_reg  <= last_next;
         hdr0_reg  <= hdr0_next;
         hdr1_reg  <= hdr1_next;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         rp_reg    <= RP_IDLE;
         rdest_reg <= 8'h00;
         bv_reg    <= 1'b0;
         bk_reg    <= 1'b0;
         bd_reg    <= 32'h0000_0000;
         disc_reg  <= 1'b0;
         nack_reg  <= 1'b0;
      end else begin
         rp_reg    <= rp_next;
         rdest_reg <= rdest_next;
         bv_reg    <= bv_next;
         bk_reg    <= bk_next;
         bd_reg    <= bd_next;
         disc_reg  <= disc_next;
         nack_reg  <= nack_next;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         v0_reg <= 1'b0;
         v1_reg <= 1'b0;
         d0_reg <= '0;
         d1_reg <= '0;
      end else begin
         v0_reg <= v0_next;
         v1_reg <= v1_next;
         d0_reg <= d0_next;
         d1_reg <= d1_next;
      end
   end

   assign lk.bwd_valid = bv_reg;
   assign lk.bwd_k     = bk_reg;
   assign lk.bwd_data  = bd_reg;
   assign o_pkt_valid  = v0_reg;
   assign o_pkt        = d0_reg;
   assign o_discard    = disc_reg;
   assign o_nack       = nack_reg;

endmodule : target_end

// ---- test/link_properties.sv ----
// checker for symbol framing and acknowledge timing on the word link
module link_properties (
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_fwd_valid,
   input  wire logic        i_fwd_k,
   input  wire logic [31:0] i_fwd_data,
   input  wire logic        i_bwd_valid,
   input  wire logic        i_bwd_k,
   input  wire logic [31:0] i_bwd_data
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   sequence sop_s;
      i_fwd_valid && i_fwd_k && i_fwd_data[10:8] == 3'h0;
   endsequence
   sequence eop_s;
      i_fwd_valid && i_fwd_k && i_fwd_data[10:8] == 3'h2;
   endsequence
   sequence ack_s;
      i_bwd_valid && i_bwd_k && i_bwd_data[10:8] == 3'h7;
   endsequence
   fwd_delim_a: assert property (
      i_fwd_valid && i_fwd_k |-> i_fwd_data[31:24] ==
      ((i_fwd_data[10:8] == 3'h0 || i_fwd_data[10:8] == 3'h2) ?
       8'h7c : 8'h1c))
      else $error("fwd symbol delimiter wrong");
   bwd_delim_a: assert property (
      i_bwd_valid && i_bwd_k |-> i_bwd_data[31:24] ==
      ((i_bwd_data[10:8] == 3'h0 || i_bwd_data[10:8] == 3'h2) ?
       8'h7c : 8'h1c))
      else $error("bwd symbol delimiter wrong");
   frame_len_a: assert property (sop_s |-> ##5 eop_s)
      else $error("frame not closed after four words");
   hdr_rsvd_a: assert property (
      sop_s |=> !i_fwd_k && i_fwd_data[26:20] == 7'h00)
      else $error("header reserved bits set");
   ttype_rsvd_a: assert property (
      sop_s |-> ##2 i_fwd_data[27:0] == 28'h0)
      else $error("second header word reserved bits set");
   pad_zero_a: assert property (
      sop_s |-> ##4 i_fwd_data[15:0] == 16'h0000)
      else $error("pad after crc not zero");
   ack_time_a: assert property (eop_s |=> ack_s)
      else $error("no answer symbol after end of packet");
   ack_code_a: assert property (
      ack_s |-> i_bwd_data[23:21] inside {3'h0, 3'h2})
      else $error("answer status neither accepted nor not accepted");
endmodule : link_properties

// ---- test/serial_packet_type_decoder_tb.sv ----
// bench: initiator and target ends joined, decode and refusal scenarios
module serial_packet_type_decoder_tb
   import link_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk = 0, i_rst_n = 0, rv = 0, mc = 0, prdy = 1;
   logic [3:0] ft = 0, tt = 0;
   logic [7:0] dst = 0;
   logic rrdy, dn, rt, er, pv, dc, nk;
   pkt_desc_type pk;
   int errors = 0, total_checks = 0, n_dn = 0, n_rt = 0, n_er = 0, n_dc = 0;
   int n_nk = 0;
   logic [4:0] cls_seen;
   pkt_desc_type pk_seen;
   logic [15:0] tbl [21] = '{16'h2402, 16'h2c03, 16'h2d04, 16'h2e05,
      16'h2f06, 16'h5407, 16'h5508, 16'h5e09, 16'h630a, 16'h790b,
      16'h800c, 16'h810d, 16'h820e, 16'h830f, 16'h8410, 16'ha511,
      16'hb112, 16'hd013, 16'hd114, 16'hd815, 16'h6f0a};
   link_if lk ();
   initiator_end initiator_end_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .lk(lk),
      .i_req_valid(rv), .i_req_ftype(ft), .i_req_ttype(tt),
      .i_req_dest(dst), .i_req_src(8'h33), .i_req_data(32'h5a5a_0f0f),
      .o_req_ready(rrdy), .o_done(dn), .o_retry(rt), .o_err_resp(er));
   target_end target_end_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .lk(lk),
      .i_primary_id(8'h11), .i_secondary_id(8'h22), .i_multicast_en(mc),
      .i_pkt_ready(prdy), .o_pkt_valid(pv), .o_pkt(pk), .o_discard(dc),
      .o_nack(nk));
   link_properties link_properties_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_fwd_valid(lk.fwd_valid), .i_fwd_k(lk.fwd_k),
      .i_fwd_data(lk.fwd_data), .i_bwd_valid(lk.bwd_valid),
      .i_bwd_k(lk.bwd_k), .i_bwd_data(lk.bwd_data));
   initial begin
      forever #5 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      n_dn += dn;
      n_rt += rt;
      n_er += er;
      n_dc += dc;
      n_nk += nk;
      if (pv && prdy) begin
         cls_seen <= pk.cls;
         pk_seen  <= pk;
      end
   end
   task automatic chk(input string nm, input logic [31:0] got, exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // one request; the error reply can trail acceptance by five cycles
   task automatic send(input logic [7:0] ftt, input logic [7:0] d);
      int n;
      for (n = 0; n < 100 && rrdy !== 1'b1; n++) @(negedge i_clk);
      // a sender that never frees up is a failure, not a silent skip
      if (rrdy !== 1'b1) errors++;
      {ft, tt} = ftt;
      dst = d;
      rv = 1;
      @(negedge i_clk) rv = 0;
      repeat (20) @(negedge i_clk);
   endtask : send
   task automatic decode_all;
      int d0;
      foreach (tbl[i]) begin
         d0 = n_dn;
         cls_seen = 5'h1f;
         send(tbl[i][15:8], 8'h11);
         chk("accepted", n_dn - d0, 1);
         chk("class", cls_seen, tbl[i][4:0]);
         chk("fields", {8'h00, pk_seen[23:0]},
             {8'h00, tbl[i][15:8], 16'h1133});
      end
   endtask : decode_all
   task automatic unsupported_types;
      logic [7:0] u [5] = '{8'h03, 8'h20, 8'h50, 8'h85, 8'hd2};
      foreach (u[i]) begin
         n_er = 0;
         send(u[i], 8'h11);
         chk("error reply", n_er, 1);
      end
   endtask : unsupported_types
   task automatic undefined_and_ids;
      logic [3:0] f [7] = '{4'h1, 4'h3, 4'h4, 4'h9, 4'hc, 4'he, 4'hf};
      foreach (f[i]) begin
         n_dc = 0;
         cls_seen = 5'h1f;
         send({f[i], 4'h0}, 8'h11);
         chk("dropped", n_dc, 1);
         chk("not routed", cls_seen, 5'h1f);
      end
      n_dc = 0;
      send(8'h60, 8'h22);
      chk("secondary id off", n_dc, 1);
      mc = 1;
      n_dc = 0;
      send(8'h60, 8'h22);
      chk("secondary id on", n_dc, 0);
      mc = 0;
   endtask : undefined_and_ids
   // full buffer is refused and the sender keeps resending
   task automatic full_retry;
      prdy = 0;
      n_rt = 0;
      n_dn = 0;
      n_nk = 0;
      send(8'h54, 8'h11);
      send(8'h54, 8'h11);
      send(8'h54, 8'h11);
      chk("retry while full", n_rt > 0, 1);
      chk("nack while full", n_nk > 0, 1);
      prdy = 1;
      send(8'h54, 8'h11);
      chk("all accepted", n_dn, 4);
   endtask : full_retry
   task automatic end_of_test;
      if (errors == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : end_of_test
   initial begin
      repeat (8) @(negedge i_clk);
      i_rst_n = 1;
      decode_all;
      unsupported_types;
      undefined_and_ids;
      full_retry;
      end_of_test;
   end
   initial begin
      #200us errors++;
      end_of_test;
   end
endmodule : serial_packet_type_decoder_tb
